// *** verilog/counter_array_mode_control.sv ***
// counter array mode control: mode and pwm config registers, timebase, counter, flags
`timescale 1ns/1ps
`include "counter_array_regs.svh"

module counter_array_mode_control (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // system status and count sources
    input wire logic cpu_idle,
    input wire logic counter_run,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_clk,
    input wire logic overflow_flag_clear,
    // counter state
    output logic [15:0] counter_value,
    output logic counter_overflow_flag,
    output logic counter_overflow_irq,
    output logic cycle_overflow_irq,
    // mode outputs
    output logic watchdog_enable,
    output logic watchdog_lock,
    output counter_array_pkg::timebase_t timebase_select,
    output logic reload_bank_select,
    output counter_array_pkg::cycle_len_t cycle_length_select
);
    import counter_array_pkg::*;

    // register state
    logic idle_suspend_q;
    logic wdog_en_q;
    logic wdog_lock_q;
    timebase_t tb_sel_q;
    logic ovf_irq_en_q;
    logic reload_sel_q;
    logic cov_irq_en_q;
    logic cov_flag_q;
    cycle_len_t cyc_len_q;
    logic [15:0] count_q;
    logic ovf_flag_q;
    logic ovf_irq_q;
    logic cov_irq_q;
    logic [7:0] rdata_q;

    // synchronisers and edge history
    logic eci_s1_q, eci_s2_q, eci_s3_q;
    logic xclk_s1_q, xclk_s2_q, xclk_s3_q;

    // decode and datapath nets
    logic sel_mode;
    logic sel_pwm;
    logic suspend;
    logic step_en;
    logic eci_fall;
    logic xclk_rise;
    logic tick_div12, tick_div4, tick_div8;
    logic tb_tick;
    logic advance;
    logic wrap;
    logic cov_event;

    // page decides which register answers at the shared address
    assign sel_mode = (sfr_addr == `MODE_CTRL_ADDR) && (sfr_page == `MODE_CTRL_PAGE);
    assign sel_pwm = (sfr_addr == `PWM_CFG_ADDR) && (sfr_page == `PWM_CFG_PAGE);

    // mode register: watchdog bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wdog_en_q <= 1'(`MD_RESET >> `MD_WDOG_ENABLE);
            wdog_lock_q <= 1'b0;
        end else if (sfr_wr && sel_mode) begin
            // setting the lock also turns the watchdog on
            wdog_lock_q <= wdog_lock_q | sfr_wdata[`MD_WDOG_LOCK];
            if (wdog_lock_q) begin
                wdog_en_q <= 1'b1;
            end else begin
                wdog_en_q <= sfr_wdata[`MD_WDOG_ENABLE] | sfr_wdata[`MD_WDOG_LOCK];
            end
        end
    end

    // mode register: fields frozen while the watchdog runs
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            idle_suspend_q <= 1'b0;
            tb_sel_q <= TB_SYSCLK_DIV12;
            ovf_irq_en_q <= 1'b0;
        end else if (sfr_wr && sel_mode && !wdog_en_q) begin
            idle_suspend_q <= sfr_wdata[`MD_IDLE_SUSPEND];
            tb_sel_q <= timebase_t'(sfr_wdata[`MD_TB_HI:`MD_TB_LO]);
            ovf_irq_en_q <= sfr_wdata[`MD_OVF_IRQ_EN];
        end
    end

    // pwm config register; unused bits 4..2 are not stored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reload_sel_q <= 1'b0;
            cov_irq_en_q <= 1'b0;
            cyc_len_q <= CYC_8BIT;
        end else if (sfr_wr && sel_pwm) begin
            reload_sel_q <= sfr_wdata[`PWM_RELOAD_SEL];
            cov_irq_en_q <= sfr_wdata[`PWM_COV_IRQ_EN];
            cyc_len_q <= cycle_len_t'(sfr_wdata[`PWM_CLSEL_HI:`PWM_CLSEL_LO]);
        end
    end

    // cycle overflow flag: hardware set wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cov_flag_q <= 1'b0;
        end else if (cov_event) begin
            cov_flag_q <= 1'b1;
        end else if (sfr_wr && sel_pwm) begin
            cov_flag_q <= sfr_wdata[`PWM_COV_FLAG];
        end
    end

    // two-stage synchronisers plus one history stage for edges
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            eci_s1_q <= 1'b1;
            eci_s2_q <= 1'b1;
            eci_s3_q <= 1'b1;
            xclk_s1_q <= 1'b0;
            xclk_s2_q <= 1'b0;
            xclk_s3_q <= 1'b0;
        end else begin
            eci_s1_q <= external_count_input;
            eci_s2_q <= eci_s1_q;
            eci_s3_q <= eci_s2_q;
            xclk_s1_q <= ext_osc_clk;
            xclk_s2_q <= xclk_s1_q;
            xclk_s3_q <= xclk_s2_q;
        end
    end

    // edges seen only after the second stage
    assign eci_fall = eci_s3_q && !eci_s2_q;
    assign xclk_rise = xclk_s2_q && !xclk_s3_q;

    // idle suspend freezes prescalers and counter alike
    assign suspend = idle_suspend_q && cpu_idle;
    assign step_en = counter_run && !suspend;

    // prescalers for the divided sources
    timebase_prescaler #(.DIV(`DIV_SYSCLK_SLOW)) u_div12 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step_en),
        .tick(tick_div12)
    );
    timebase_prescaler #(.DIV(`DIV_SYSCLK_FAST)) u_div4 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step_en),
        .tick(tick_div4)
    );
    timebase_prescaler #(.DIV(`DIV_EXT_CLK)) u_div8 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step_en && xclk_rise),
        .tick(tick_div8)
    );

    // timebase source mux
    always_comb begin
        unique case (tb_sel_q)
            TB_SYSCLK_DIV12: tb_tick = tick_div12;
            TB_SYSCLK_DIV4: tb_tick = tick_div4;
            TB_TIMER0_OVF: tb_tick = timer0_overflow;
            TB_EXT_INPUT_FALL: tb_tick = eci_fall;
            TB_SYSCLK: tb_tick = 1'b1;
            TB_EXT_CLK_DIV8: tb_tick = tick_div8;
            TB_RESERVED_6, TB_RESERVED_7: tb_tick = 1'b0;
        endcase
    end

    assign advance = step_en && tb_tick;
    assign wrap = advance && (count_q == `CNT_ALL_ONES);

    // cycle overflow from the low 8..11 bits rolling over
    always_comb begin
        unique case (cyc_len_q)
            CYC_8BIT: cov_event = advance && (&count_q[7:0]);
            CYC_9BIT: cov_event = advance && (&count_q[8:0]);
            CYC_10BIT: cov_event = advance && (&count_q[9:0]);
            CYC_11BIT: cov_event = advance && (&count_q[10:0]);
        endcase
    end

    // sixteen-bit counter
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_q <= 16'h0000;
        end else if (advance) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // overflow flag: set on wrap, cleared by software, set wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ovf_flag_q <= 1'b0;
        end else if (wrap) begin
            ovf_flag_q <= 1'b1;
        end else if (overflow_flag_clear) begin
            ovf_flag_q <= 1'b0;
        end
    end

    // masked interrupt requests
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ovf_irq_q <= 1'b0;
            cov_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_flag_q && ovf_irq_en_q;
            cov_irq_q <= cov_flag_q && cov_irq_en_q;
        end
    end

    // registered read data; unused bits forced to zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd && sel_mode) begin
            rdata_q <= {idle_suspend_q, wdog_en_q, wdog_lock_q, 1'b0, tb_sel_q, ovf_irq_en_q};
        end else if (sfr_rd && sel_pwm) begin
            rdata_q <= {reload_sel_q, cov_irq_en_q, cov_flag_q, 3'b000, cyc_len_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata = rdata_q;
    assign counter_value = count_q;
    assign counter_overflow_flag = ovf_flag_q;
    assign counter_overflow_irq = ovf_irq_q;
    assign cycle_overflow_irq = cov_irq_q;
    assign watchdog_enable = wdog_en_q;
    assign watchdog_lock = wdog_lock_q;
    assign timebase_select = tb_sel_q;
    assign reload_bank_select = reload_sel_q;
    assign cycle_length_select = cyc_len_q;
endmodule

// *** verilog/counter_array_regs.svh ***
// register addresses, field positions, reset values and counts for the counter array
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

// special-function addresses and pages
`define MODE_CTRL_ADDR 8'hD9
`define MODE_CTRL_PAGE 8'h00
`define PWM_CFG_ADDR 8'hD9
`define PWM_CFG_PAGE 8'h0F

// counter_mode_control fields
`define MD_IDLE_SUSPEND 7
`define MD_WDOG_ENABLE 6
`define MD_WDOG_LOCK 5
`define MD_UNUSED 4
`define MD_TB_HI 3
`define MD_TB_LO 1
`define MD_OVF_IRQ_EN 0
`define MD_RESET 8'h40

// pwm_cycle_config fields
`define PWM_RELOAD_SEL 7
`define PWM_COV_IRQ_EN 6
`define PWM_COV_FLAG 5
`define PWM_CLSEL_HI 1
`define PWM_CLSEL_LO 0
`define PWM_RESET 8'h00

// counter wrap point and prescale ratios
`define CNT_ALL_ONES 16'hFFFF
`define DIV_SYSCLK_SLOW 12
`define DIV_SYSCLK_FAST 4
`define DIV_EXT_CLK 8

`endif

// *** verilog/counter_array_pkg.sv ***
// types shared by the counter array mode-control logic
package counter_array_pkg;

    // counter increment source codes
    typedef enum logic [2:0] {
        TB_SYSCLK_DIV12 = 3'b000,
        TB_SYSCLK_DIV4 = 3'b001,
        TB_TIMER0_OVF = 3'b010,
        TB_EXT_INPUT_FALL = 3'b011,
        TB_SYSCLK = 3'b100,
        TB_EXT_CLK_DIV8 = 3'b101,
        TB_RESERVED_6 = 3'b110,
        TB_RESERVED_7 = 3'b111
    } timebase_t;

    // pwm cycle length codes
    typedef enum logic [1:0] {
        CYC_8BIT = 2'b00,
        CYC_9BIT = 2'b01,
        CYC_10BIT = 2'b10,
        CYC_11BIT = 2'b11
    } cycle_len_t;

endpackage

// *** verilog/timebase_prescaler.sv ***
// divide-by-n prescaler giving one tick per n input steps
`timescale 1ns/1ps

module timebase_prescaler #(
    parameter int DIV = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // step in, tick out
    input wire logic step,
    output logic tick
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    // wrap counter, advances only on a step
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
        end
    end

    // tick on the step that closes a group
    assign tick = step && (cnt_q == LAST);
endmodule

// *** verification/counter_array_mode_control_chk.sv ***
// port assertions for the counter array mode control
`timescale 1ns/1ps

module counter_array_mode_control_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // counter and mode state
    input wire logic overflow_flag_clear,
    input wire logic [15:0] counter_value,
    input wire logic counter_overflow_flag,
    input wire logic counter_overflow_irq,
    input wire logic watchdog_enable,
    input wire logic watchdog_lock,
    input wire counter_array_pkg::timebase_t timebase_select
);
    import counter_array_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // address decode of the two registers
    wire mode_wr = sfr_wr && sfr_addr == 8'hD9 && sfr_page == 8'h00;
    wire mode_rd = sfr_rd && sfr_addr == 8'hD9 && sfr_page == 8'h00;
    wire pwm_rd = sfr_rd && sfr_addr == 8'hD9 && sfr_page == 8'h0F;
    // counter rolls from all ones to zero
    sequence s_wrap;
        counter_value == 16'hFFFF ##1 counter_value == 16'h0000;
    endsequence
    a_reset_wdog_on:
    assert property (disable iff (1'b0) !nrst |=> watchdog_enable && !watchdog_lock)
        else $error("watchdog not on after reset");
    a_lock_holds_enable:
    assert property (watchdog_lock |=> watchdog_lock && watchdog_enable)
        else $error("locked watchdog dropped");
    a_unlock_disable:
    assert property (mode_wr && !watchdog_lock && sfr_wdata[6:5] == 2'b00 |=> !watchdog_enable)
        else $error("watchdog not disabled");
    a_mode_frozen:
    assert property (mode_wr && watchdog_enable |=> $stable(timebase_select))
        else $error("timebase changed while watchdog on");
    a_wrap_sets_flag:
    assert property (s_wrap |-> counter_overflow_flag)
        else $error("wrap did not set flag");
    a_flag_sticky:
    assert property (counter_overflow_flag && !overflow_flag_clear |=> counter_overflow_flag)
        else $error("flag dropped without clear");
    a_irq_needs_flag:
    assert property (counter_overflow_irq |-> $past(counter_overflow_flag))
        else $error("irq without flag");
    a_rdata_idle_zero:
    assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data without read");
    a_mode_bit_four:
    assert property (mode_rd |=> sfr_rdata[4] == 1'b0)
        else $error("mode bit 4 not zero");
    a_pwm_unused_zero:
    assert property (pwm_rd |=> sfr_rdata[4:2] == 3'b000)
        else $error("pwm unused bits not zero");
endmodule

bind counter_array_mode_control counter_array_mode_control_chk u_chk (.ref_clk, .nrst,
    .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .overflow_flag_clear,
    .counter_value, .counter_overflow_flag, .counter_overflow_irq, .watchdog_enable,
    .watchdog_lock, .timebase_select);

// *** verification/counter_array_mode_control_tb.sv ***
// register-level testbench for the counter array mode control
`timescale 1ns/1ps

module counter_array_mode_control_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'hD9;
    logic [7:0] sfr_page = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, rv;
    logic cpu_idle = 1'b0;
    logic counter_run = 1'b1;
    logic timer0_overflow = 1'b0;
    logic external_count_input = 1'b1;
    logic ext_osc_clk = 1'b0;
    logic overflow_flag_clear = 1'b0;
    logic [15:0] counter_value;
    logic counter_overflow_flag, counter_overflow_irq, cycle_overflow_irq;
    logic watchdog_enable, watchdog_lock, reload_bank_select;
    counter_array_pkg::timebase_t timebase_select;
    counter_array_pkg::cycle_len_t cycle_length_select;
    int fail_count = 0;
    int checks = 0;
    int exp_tab[8] = '{4, 12, 8, 4, 48, 1, 0, 0};

    counter_array_mode_control u_dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .counter_run(counter_run),
        .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
        .ext_osc_clk(ext_osc_clk), .overflow_flag_clear(overflow_flag_clear),
        .counter_value(counter_value), .counter_overflow_flag(counter_overflow_flag),
        .counter_overflow_irq(counter_overflow_irq), .cycle_overflow_irq(cycle_overflow_irq),
        .watchdog_enable(watchdog_enable), .watchdog_lock(watchdog_lock),
        .timebase_select(timebase_select), .reload_bank_select(reload_bank_select),
        .cycle_length_select(cycle_length_select));

    // 100 ns clock
    always #50 ref_clk = ~ref_clk;

    // comparison with count of mismatches
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe, called at a falling edge, then one idle cycle
    task automatic wr(input logic [7:0] pg, input logic [7:0] d);
        sfr_page = pg;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    // one-cycle read strobe, data sampled the cycle after, then one idle cycle
    task automatic rd(input logic [7:0] pg, output logic [7:0] d);
        sfr_page = pg;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
        @(negedge ref_clk);
    endtask

    // set a mode, drive the count sources for the first 32 of 48 cycles, compare the counter step
    task automatic measure(input logic [7:0] mode, input logic [15:0] exp);
        logic [15:0] c0;
        wr(8'h00, mode);
        chk("timebase", 16'(mode[3:1]), 16'(timebase_select));
        repeat (4) @(negedge ref_clk);
        c0 = counter_value;
        for (int i = 0; i < 48; i++) begin
            @(negedge ref_clk);
            timer0_overflow = (i % 4 == 1) && (i < 32);
            if (i % 4 == 0 && i < 32) external_count_input = ~external_count_input;
            if (i % 2 == 0 && i < 32) ext_osc_clk = ~ext_osc_clk;
        end
        chk("count step", exp, counter_value - c0);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, about 80000 cycles
    initial begin
        #8000000;
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        rd(8'h00, rv);
        chk("mode reset", 16'h0040, 16'(rv));
        rd(8'h0F, rv);
        chk("pwm reset", 16'h0000, 16'(rv));
        wr(8'h00, 8'h08);
        chk("wdog off", 16'h0000, 16'(watchdog_enable));
        chk("tb frozen", 16'h0000, 16'(timebase_select));
        wr(8'h00, 8'h9F);
        rd(8'h00, rv);
        chk("mode rd", 16'h008F, 16'(rv));
        cpu_idle = 1'b1;
        measure(8'h88, 16'h0000);
        measure(8'h08, 16'h0030);
        cpu_idle = 1'b0;
        for (int k = 0; k < 8; k++) measure({4'h0, k[2:0], 1'b1}, exp_tab[k][15:0]);
        wr(8'h00, 8'h09);
        for (int i = 0; i < 70000 && counter_overflow_flag !== 1'b1; i++) @(negedge ref_clk);
        chk("flag", 16'h0001, 16'(counter_overflow_flag));
        @(negedge ref_clk);
        chk("irq", 16'h0001, 16'(counter_overflow_irq));
        wr(8'h00, 8'h08);
        @(negedge ref_clk);
        chk("irq masked", 16'h0000, 16'(counter_overflow_irq));
        chk("flag held", 16'h0001, 16'(counter_overflow_flag));
        overflow_flag_clear = 1'b1;
        @(negedge ref_clk);
        overflow_flag_clear = 1'b0;
        @(negedge ref_clk);
        chk("flag clr", 16'h0000, 16'(counter_overflow_flag));
        wr(8'h0F, 8'hFF);
        rd(8'h0F, rv);
        chk("pwm rd", 16'h00E3, 16'(rv));
        chk("cyc irq", 16'h0001, 16'(cycle_overflow_irq));
        chk("cyc len", 16'h0003, 16'(cycle_length_select));
        chk("reload", 16'h0001, 16'(reload_bank_select));
        wr(8'h01, 8'hFF);
        rd(8'h01, rv);
        chk("unmapped", 16'h0000, 16'(rv));
        rd(8'h00, rv);
        chk("mode kept", 16'h0008, 16'(rv));
        wr(8'h00, 8'h28);
        chk("lock", 16'h0003, 16'({watchdog_lock, watchdog_enable}));
        wr(8'h00, 8'h00);
        chk("locked on", 16'h0001, 16'(watchdog_enable));
        wr(8'h00, 8'h0E);
        chk("tb locked", 16'h0004, 16'(timebase_select));
        nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        chk("rst wdog", 16'h0001, 16'({watchdog_lock, watchdog_enable}));
        chk("rst tb", 16'h0000, 16'(timebase_select));
        report_and_stop();
    end
endmodule
